// file: hw/tcl_core.sv
/*
 * digital control core: temperature indexed offset and span trim fetch,
 * coefficient and configuration registers, lock and unlock gating.
 * assumes a same-clock byte memory answering reads with nvm_ack_in,
 * a same-clock serial decoder, and an asynchronous unlock pin.
 */
// Overview of operation
// - in locked mode, each millisecond the indexed offset word loads the offset dac
// - offset table has 176 sixteen-bit entries, one per index
// - index clamps at zero for readings below the table
// - index clamps at the last entry; no wraparound in either table
// - span dac word comes from a second table with the same index
// - span table also holds 176 entries and is clamped alike
// - one index step stands for about 1.5 degrees c
// - gain code selects one of 16 amplifier gain settings
// - every dac trim code is a full 16-bit unsigned word
// - offset tc and span tc dacs each have their own 16-bit register
// - one configuration bit selects internal or external feedback resistors
// - calibration data lives in a 768-byte nonvolatile memory
// - when locked, calibration values and user bytes may not change
// - high unlock pin overrides the lock and reopens calibration
// - serial pin time-shares a line with the sensor output
// - after reset in locked mode, configuration and tc words are loaded
// - in locked mode all five registers refresh each 1 ms tick
// - locked mode needs lock byte ff and unlock pin low
// - lock byte 00 or unlock high lets serial commands load registers
`timescale 1ns/1ps
`include "tcl_consts.svh"
module tcl_core #(
	parameter int PERIOD_CYC = `TCL_PERIOD_NS / `TCL_CLK_NS
) (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic signed [9:0] temp_raw_in,
	input wire logic unlock_in,
	input wire tcl_pkg::tcl_host_wr_t host_wr_in,
	input wire logic serial_busy_in,
	input wire logic nvm_ack_in,
	input wire logic [7:0] nvm_data_in,
	output tcl_pkg::tcl_nvm_req_t nvm_req_out,
	output logic [15:0] offset_trim_dac_out,
	output logic [15:0] span_trim_dac_out,
	output logic [15:0] offset_tc_coeff_out,
	output logic [15:0] span_tc_coeff_out,
	output logic [15:0] config_out,
	output logic [3:0] gain_stage_out,
	output logic ext_fb_sel_out,
	output logic [7:0] temp_index_out,
	output logic locked_out,
	output logic write_allow_out,
	output logic sensor_out_en_out
);
	import tcl_pkg::*;

	logic u1_r, u2_r, u3_r, unl_r, unl_nxt;
	logic [31:0] tmr_r, tmr_nxt;
	logic tick_r, tick_nxt;
	tcl_state_t st_r, st_nxt;
	logic [2:0] step_r, step_nxt;
	logic [7:0] idx_r, idx_nxt, lock_r, lock_nxt, lo_r, lo_nxt;
	logic [15:0] cfg_r, cfg_nxt, offset_trim_dac_r, offset_trim_dac_nxt, otc_r, otc_nxt;
	logic [15:0] sdac_r, sdac_nxt, stc_r, stc_nxt, word;
	logic norm_r, norm_nxt, ser_ok_r, ser_ok_nxt, sen_r, sen_nxt;
	tcl_nvm_req_t req_r, req_nxt;
	logic [9:0] base;

	// unlock pin: three stages, a change counts when stages two and three agree
	always_comb begin
		unl_nxt = unl_r;
		if (u2_r == u3_r) begin
			unl_nxt = u3_r;
		end
	end
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			u1_r <= 1'b0;
			u2_r <= 1'b0;
			u3_r <= 1'b0;
			unl_r <= 1'b0;
		end else begin
			u1_r <= unlock_in;
			u2_r <= u1_r;
			u3_r <= u2_r;
			unl_r <= unl_nxt;
		end
	end

	// mode and output mux: locked mode versus serial calibration
	always_comb begin
		norm_nxt = (lock_r == `TCL_LOCK_SET) && !unl_r;
		ser_ok_nxt = (lock_r == `TCL_LOCK_OPEN) || unl_r;
		sen_nxt = !serial_busy_in;
	end

	// one millisecond index timer
	always_comb begin
		tmr_nxt = tmr_r + 32'h1;
		tick_nxt = 1'b0;
		if (tmr_r >= 32'(PERIOD_CYC - 1)) begin
			tmr_nxt = 32'h0;
			tick_nxt = 1'b1;
		end
	end

	// clamped table index, one step is roughly 1.5 degrees c
	function automatic logic [7:0] clamp_idx(input logic signed [9:0] t);
		logic [7:0] r;
		r = t[7:0];
		if (t < 10'sh000) begin
			r = 8'h00;
		end else if (t > $signed({2'b00, `TCL_IDX_MAX})) begin
			r = `TCL_IDX_MAX;
		end
		return r;
	endfunction

	// span table sits in two parts; the upper indexes live lower in memory
	always_comb begin
		base = `TCL_OFFSET_TRIM_DAC_BASE + {1'b0, idx_r, 1'b0};
		if (idx_r >= `TCL_IDX_SPLIT) begin
			base = `TCL_SPAN_BASE_HI + {1'b0, idx_r - `TCL_IDX_SPLIT, 1'b0};
		end else begin
			base = `TCL_SPAN_BASE_LO + {1'b0, idx_r, 1'b0};
		end
		case (step_r)
			3'h0: base = `TCL_LOCK_ADDR;
			3'h1: base = `TCL_CFG_ADDR;
			3'h2: base = `TCL_OTC_ADDR;
			3'h3: base = `TCL_STC_ADDR;
			3'h4: base = `TCL_OFFSET_TRIM_DAC_BASE + {1'b0, idx_r, 1'b0};
			default: begin
			end
		endcase
	end

	// fetch sequencer and calibration registers
	always_comb begin
		st_nxt = st_r;
		step_nxt = step_r;
		idx_nxt = idx_r;
		lo_nxt = lo_r;
		lock_nxt = lock_r;
		cfg_nxt = cfg_r;
		offset_trim_dac_nxt = offset_trim_dac_r;
		otc_nxt = otc_r;
		sdac_nxt = sdac_r;
		stc_nxt = stc_r;
		req_nxt = req_r;
		word = {nvm_data_in, lo_r};
		case (st_r)
			TCL_ST_IDLE: begin
				if (tick_r) begin
					st_nxt = TCL_ST_LO;
					step_nxt = 3'h0;
					idx_nxt = clamp_idx(temp_raw_in);
				end
			end
			TCL_ST_LO: begin
				req_nxt.rd = 1'b1;
				req_nxt.addr = base;
				if (req_r.rd && nvm_ack_in) begin
					lo_nxt = nvm_data_in;
					req_nxt.addr = base + 10'h1;
					st_nxt = TCL_ST_HI;
				end
			end
			TCL_ST_HI: begin
				if (nvm_ack_in) begin
					req_nxt.rd = 1'b0;
					st_nxt = TCL_ST_LO;
					step_nxt = step_r + 3'h1;
					case (step_r)
						3'h0: begin
							lock_nxt = lo_r;
							if (lo_r != `TCL_LOCK_SET || unl_r) begin
								st_nxt = TCL_ST_IDLE;
							end
						end
						3'h1: cfg_nxt = word;
						3'h2: otc_nxt = word;
						3'h3: stc_nxt = word;
						3'h4: offset_trim_dac_nxt = word;
						default: begin
							sdac_nxt = word;
							st_nxt = TCL_ST_IDLE;
						end
					endcase
				end
			end
			default: st_nxt = TCL_ST_IDLE;
		endcase
		// serial loads only while calibration is open
		if (host_wr_in.wr && ser_ok_r && st_r == TCL_ST_IDLE) begin
			case (host_wr_in.sel)
				TCL_SEL_CFG: cfg_nxt = host_wr_in.data;
				TCL_SEL_OFFSET_TRIM_DAC: offset_trim_dac_nxt = host_wr_in.data;
				TCL_SEL_OTC: otc_nxt = host_wr_in.data;
				TCL_SEL_SDAC: sdac_nxt = host_wr_in.data;
				TCL_SEL_STC: stc_nxt = host_wr_in.data;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			tmr_r <= 32'h0;
			tick_r <= 1'b1; // first fetch right after reset
			st_r <= TCL_ST_IDLE;
			step_r <= 3'h0;
			idx_r <= 8'h00;
			lo_r <= 8'h00;
			// treated as locked until the stored lock byte has been read
			lock_r <= `TCL_LOCK_SET;
			cfg_r <= `TCL_WORD_RST;
			offset_trim_dac_r <= `TCL_WORD_RST;
			otc_r <= `TCL_WORD_RST;
			sdac_r <= `TCL_WORD_RST;
			stc_r <= `TCL_WORD_RST;
			req_r <= '0;
			norm_r <= 1'b0;
			ser_ok_r <= 1'b0;
			sen_r <= 1'b1;
		end else begin
			tmr_r <= tmr_nxt;
			tick_r <= tick_nxt;
			st_r <= st_nxt;
			step_r <= step_nxt;
			idx_r <= idx_nxt;
			lo_r <= lo_nxt;
			lock_r <= lock_nxt;
			cfg_r <= cfg_nxt;
			offset_trim_dac_r <= offset_trim_dac_nxt;
			otc_r <= otc_nxt;
			sdac_r <= sdac_nxt;
			stc_r <= stc_nxt;
			req_r <= req_nxt;
			norm_r <= norm_nxt;
			ser_ok_r <= ser_ok_nxt;
			sen_r <= sen_nxt;
		end
	end

	// outputs straight from registers; 768-byte memory holds the images
	assign nvm_req_out = req_r;
	assign offset_trim_dac_out = offset_trim_dac_r;
	assign span_trim_dac_out = sdac_r;
	assign offset_tc_coeff_out = otc_r;
	assign span_tc_coeff_out = stc_r;
	assign config_out = cfg_r;
	assign gain_stage_out = cfg_r[`TCL_GAIN_MSB:`TCL_GAIN_LSB];
	assign ext_fb_sel_out = cfg_r[`TCL_EXTFB_BIT];
	assign temp_index_out = idx_r;
	assign locked_out = norm_r;
	assign write_allow_out = ser_ok_r;
	assign sensor_out_en_out = sen_r;

	// checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);

	idx_top_a: assert property (idx_r <= `TCL_IDX_MAX)
		else $error("index beyond last entry");
	idx_low_a: assert property ((st_r == TCL_ST_IDLE && tick_r
		&& temp_raw_in < 10'sh000) |=> idx_r == 8'h00)
		else $error("negative reading not clamped");
	tick_fetch_a: assert property ((st_r == TCL_ST_IDLE && tick_r)
		|=> st_r == TCL_ST_LO ##1 req_r.rd && req_r.addr == `TCL_LOCK_ADDR)
		else $error("tick did not start a fetch");
	lock_hold_a: assert property ((host_wr_in.wr && !ser_ok_r
		&& st_r == TCL_ST_IDLE) |=> $stable(otc_r) && $stable(cfg_r))
		else $error("locked write changed a register");
	host_load_a: assert property ((host_wr_in.wr && ser_ok_r
		&& st_r == TCL_ST_IDLE && host_wr_in.sel == TCL_SEL_OFFSET_TRIM_DAC)
		|=> offset_trim_dac_r == $past(host_wr_in.data))
		else $error("serial write not loaded");
	word_whole_a: assert property (($past(st_r) != TCL_ST_HI
		&& !$past(host_wr_in.wr)) |-> $stable(offset_trim_dac_r) && $stable(sdac_r))
		else $error("dac changed outside a whole word");
	span_addr_a: assert property ((st_r == TCL_ST_LO && step_r == `TCL_STEP_LAST
		&& idx_r >= `TCL_IDX_SPLIT && !nvm_ack_in)
		|=> req_r.addr == `TCL_SPAN_BASE_HI
		+ {1'b0, idx_r - `TCL_IDX_SPLIT, 1'b0})
		else $error("span upper part misaddressed");
	mux_out_a: assert property (serial_busy_in |=> !sensor_out_en_out)
		else $error("output not released for serial");
	unlock_ovr_a: assert property (unl_r |=> !locked_out && write_allow_out)
		else $error("unlock pin did not override");

	full_fetch_c: cover property (st_r == TCL_ST_HI && step_r == `TCL_STEP_LAST
		&& nvm_ack_in);
	host_wr_c: cover property (host_wr_in.wr && ser_ok_r);
	clamp_hi_c: cover property (idx_r == `TCL_IDX_MAX);
endmodule

// file: hw/tcl_consts.svh
/*
 * constants of the temperature indexed calibration lookup core.
 * assumes byte wide nonvolatile memory, low byte at the even address.
 */
`ifndef TCL_CONSTS_SVH
`define TCL_CONSTS_SVH
`define TCL_IDX_MAX 8'haf
`define TCL_IDX_SPLIT 8'h80
`define TCL_OFFSET_TRIM_DAC_BASE 10'h000
`define TCL_SPAN_BASE_LO 10'h200
`define TCL_SPAN_BASE_HI 10'h1a0
`define TCL_CFG_ADDR 10'h160
`define TCL_OTC_ADDR 10'h164
`define TCL_STC_ADDR 10'h168
`define TCL_LOCK_ADDR 10'h16a
`define TCL_LOCK_SET 8'hff
`define TCL_LOCK_OPEN 8'h00
`define TCL_GAIN_MSB 3
`define TCL_GAIN_LSB 0
`define TCL_EXTFB_BIT 4
`define TCL_WORD_RST 16'h0000
`define TCL_PERIOD_NS 1000000
`define TCL_CLK_NS 8
`define TCL_STEP_LAST 3'h5
`endif

// file: hw/tcl_pkg.sv
/*
 * types shared by the calibration lookup core.
 * assumes tcl_consts.svh is included where constants are needed.
 */
package tcl_pkg;
	typedef enum logic [2:0] {
		TCL_SEL_CFG, TCL_SEL_OFFSET_TRIM_DAC, TCL_SEL_OTC, TCL_SEL_SDAC, TCL_SEL_STC
	} tcl_sel_t;
	typedef struct packed {
		logic wr;
		tcl_sel_t sel;
		logic [15:0] data;
	} tcl_host_wr_t;
	typedef struct packed {
		logic rd;
		logic [9:0] addr;
	} tcl_nvm_req_t;
	typedef enum {TCL_ST_IDLE, TCL_ST_LO, TCL_ST_HI} tcl_state_t;
endpackage

// file: tb/tcl_nvm_model.sv
/*
 * byte wide nonvolatile memory model answering core reads.
 * assumes the bench fills mem through hierarchy before reset ends.
 */
`timescale 1ns/1ps
module tcl_nvm_model (
	input wire logic clk_in,
	input wire logic [2:0] dly_in,
	input wire tcl_pkg::tcl_nvm_req_t req_in,
	output logic ack_out,
	output logic [7:0] data_out
);
	import tcl_pkg::*;
	logic [7:0] mem [0:767];
	logic [9:0] last_r = 10'h000;
	logic done_r = 1'b0;
	logic [2:0] cnt_r = 3'h0;
	initial ack_out = 1'b0;
	initial data_out = 8'h00;
	// one byte per address, acked a cycle or more after the address settles
	always @(posedge clk_in) begin
		last_r <= req_in.addr;
		if (!req_in.rd || req_in.addr != last_r) begin
			ack_out <= 1'b0;
			data_out <= ~data_out; // released bus never holds the last byte
			done_r <= 1'b0;
			cnt_r <= 3'h0;
		end else if (!done_r && !ack_out && cnt_r >= dly_in) begin
			ack_out <= 1'b1;
			data_out <= mem[req_in.addr];
			done_r <= 1'b1;
		end else begin
			ack_out <= 1'b0;
			data_out <= ~data_out;
			if (!done_r && !ack_out)
				cnt_r <= cnt_r + 3'h1;
		end
	end
endmodule

// file: tb/temp_indexed_calibration_lookup_test.sv
/*
 * bench for tcl_core: locked table fetch, clamping, host writes, lock gate.
 * assumes tcl_nvm_model as the memory and a short tick period.
 */
`timescale 1ns/1ps
module temp_indexed_calibration_lookup_test;
	import tcl_pkg::*;
	logic clk = 1'b0, srst = 1'b1, unl = 1'b0, busy = 1'b0, bq = 1'b0;
	logic signed [9:0] temp = 10'sh000;
	tcl_host_wr_t hw = '0;
	tcl_nvm_req_t req;
	logic ack, efb, lk, wa, sen;
	logic [7:0] nd, idx;
	logic [2:0] dly = 3'h0;
	logic [15:0] od, sd, otc, stc, cfg, w;
	logic [15:0] wv [5];
	logic [3:0] gain;
	int errors = 0, check_count = 0, cyc = 0, i, j, t, e;
	int tv [8] = '{-512, -1, 0, 127, 128, 175, 176, 511};
	tcl_core #(.PERIOD_CYC(200)) dut (.ref_clk_in(clk), .srst_in(srst),
		.temp_raw_in(temp), .unlock_in(unl), .host_wr_in(hw),
		.serial_busy_in(busy), .nvm_ack_in(ack), .nvm_data_in(nd),
		.nvm_req_out(req), .offset_trim_dac_out(od), .span_trim_dac_out(sd),
		.offset_tc_coeff_out(otc), .span_tc_coeff_out(stc), .config_out(cfg),
		.gain_stage_out(gain), .ext_fb_sel_out(efb), .temp_index_out(idx),
		.locked_out(lk), .write_allow_out(wa), .sensor_out_en_out(sen));
	tcl_nvm_model nvm (.clk_in(clk), .dly_in(dly), .req_in(req),
		.ack_out(ack), .data_out(nd));
	initial begin
		forever #4 clk = ~clk;
	end
	// expected word, high byte at the odd address
	function automatic logic [15:0] wd(input int a);
		return {nvm.mem[a + 1], nvm.mem[a]};
	endfunction
	function automatic int spa(input int x);
		return (x < 128) ? 512 + 2 * x : 416 + 2 * (x - 128);
	endfunction
	function automatic logic [15:0] rv(input int s);
		case (s)
			0: return cfg;
			1: return od;
			2: return otc;
			3: return sd;
			default: return stc;
		endcase
	endfunction
	task automatic chk(input string n, input logic [15:0] x,
		input logic [15:0] g);
		check_count++;
		if (g !== x) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// wait for the high byte ack of address a, bounded
	task automatic wait_done(input logic [9:0] a);
		int n;
		for (n = 0; n < 1000; n++) begin
			@(posedge clk);
			if (ack === 1'b1 && req.rd === 1'b1 && req.addr === a)
				break;
		end
		if (n == 1000)
			chk("fetch", 16'h0, 16'h1);
		repeat (2) @(posedge clk);
	endtask
	task automatic hwrite(input tcl_sel_t s, input logic [15:0] d);
		@(posedge clk) hw <= '{wr: 1'b1, sel: s, data: d};
		@(posedge clk) hw.wr <= 1'b0;
		@(negedge clk);
	endtask
	// random serial activity and output enable follow-up
	always @(posedge clk) begin
		busy <= 1'($urandom);
		cyc++;
		if (cyc == 20000) begin
			$display("[ERR] cycle_limit expected %0d seen %0d", 19999, cyc);
			errors++;
			complete_run();
		end
	end
	always @(negedge clk) begin
		if (cyc > 16)
			chk("sensor_en", {15'h0, ~bq}, {15'h0, sen});
		bq <= busy;
	end
	initial begin
		void'($urandom(32'h00d8));
		for (i = 0; i < 768; i++)
			nvm.mem[i] = 8'($urandom);
		nvm.mem[10'h16a] = 8'hff;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		// locked refresh over corner and random temperatures
		for (i = 0; i < 10; i++) begin
			t = (i < 8) ? tv[i] : int'($urandom_range(1023)) - 512;
			e = (t < 0) ? 0 : (t > 175) ? 175 : t;
			for (j = 0; j < 10; j++)
				nvm.mem[10'h160 + j] = 8'($urandom);
			dly <= i[0] ? 3'h5 : 3'h0;
			temp <= 10'(t);
			wait_done(10'(spa(e) + 1));
			w = wd(10'h160);
			chk("index", 16'(e), {8'h0, idx});
			chk("offset_dac", wd(2 * e), od);
			chk("span_dac", wd(spa(e)), sd);
			chk("config", w, cfg);
			chk("otc", wd(10'h164), otc);
			chk("stc", wd(10'h168), stc);
			chk("gain", {12'h0, w[3:0]}, {12'h0, gain});
			chk("ext_fb", {15'h0, w[4]}, {15'h0, efb});
			chk("locked", 16'h1, {15'h0, lk});
		end
		$display("test locked refresh done");
		unl <= 1'b1;
		wait_done(10'h16b);
		wait_done(10'h16b);
		chk("allow", 16'h1, {15'h0, wa});
		chk("locked", 16'h0, {15'h0, lk});
		for (i = 0; i < 5; i++) begin
			wv[i] = 16'($urandom);
			hwrite(tcl_sel_t'(i), wv[i]);
		end
		wait_done(10'h16b);
		for (i = 0; i < 5; i++)
			chk("host_reg", wv[i], rv(i));
		$display("test unlock pin done");
		nvm.mem[10'h16a] = 8'h00;
		unl <= 1'b0;
		wait_done(10'h16b);
		wait_done(10'h16b);
		chk("allow", 16'h1, {15'h0, wa});
		w = ~od;
		hwrite(TCL_SEL_OFFSET_TRIM_DAC, w);
		chk("open_write", w, od);
		$display("test open lock byte done");
		nvm.mem[10'h16a] = 8'hff;
		wait_done(10'h16b);
		wait_done(10'(spa(e) + 1));
		chk("allow", 16'h0, {15'h0, wa});
		w = od;
		hwrite(TCL_SEL_OFFSET_TRIM_DAC, ~w);
		chk("locked_write", w, od);
		$display("test lock refusal done");
		complete_run();
	end
endmodule
